//--- hdl/ess_pkg.sv
/*
  Package for the exposure start sequencer: register offsets, field
  positions, field codes, reset values and the sequencer state type.
  Assumes a 32-bit register port with byte offsets on 8 address bits.
*/
package ess_pkg;

  localparam int unsigned ESS_ADDR_W = 8;
  localparam int unsigned ESS_DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] ESS_REG_CTRL    = 8'h00;
  localparam logic [7:0] ESS_REG_TRIG    = 8'h04;
  localparam logic [7:0] ESS_REG_SWTRIG  = 8'h08;
  localparam logic [7:0] ESS_REG_SHUTTER = 8'h0c;
  localparam logic [7:0] ESS_REG_FORMAT  = 8'h10;
  localparam logic [7:0] ESS_REG_FRCTRL  = 8'h14;
  localparam logic [7:0] ESS_REG_FRPER   = 8'h18;
  localparam logic [7:0] ESS_REG_STATUS  = 8'h1c;
  localparam logic [7:0] ESS_REG_EFFPER  = 8'h20;

  // capture control fields
  localparam int unsigned ESS_CTRL_SINGLE = 0;
  localparam int unsigned ESS_CTRL_FREE   = 1;

  // trigger mode fields
  localparam int unsigned ESS_TRIG_EN    = 0;
  localparam int unsigned ESS_TRIG_SRC_L = 1;
  localparam int unsigned ESS_TRIG_SRC_H = 3;
  localparam int unsigned ESS_TRIG_MOD_L = 4;
  localparam int unsigned ESS_TRIG_MOD_H = 7;
  localparam logic [2:0]  ESS_SRC_SOFT   = 3'h7;
  localparam logic [3:0]  ESS_MODE_PROG  = 4'h0;

  // software trigger field
  localparam int unsigned ESS_SWTRIG_BIT = 0;

  // video format and rate index fields
  localparam int unsigned ESS_FMT_L   = 0;
  localparam int unsigned ESS_FMT_H   = 2;
  localparam int unsigned ESS_RATE_L  = 4;
  localparam int unsigned ESS_RATE_H  = 6;
  localparam logic [2:0]  ESS_FMT_MAX_FIXED = 3'h2;
  localparam logic [2:0]  ESS_FMT_SCALABLE  = 3'h7;

  // manual rate control field
  localparam int unsigned ESS_FRCTRL_ON = 0;

  // status fields
  localparam int unsigned ESS_ST_STATE_L = 0;
  localparam int unsigned ESS_ST_STATE_H = 1;
  localparam int unsigned ESS_ST_EXPOSE  = 2;
  localparam int unsigned ESS_ST_PERDONE = 3;
  localparam int unsigned ESS_ST_TRIGSEL = 4;

  // reset values and the constant one
  localparam logic [31:0] ESS_SHUTTER_RST = 32'h0000_03e8;
  localparam logic [31:0] ESS_FRPER_RST   = 32'h0000_0000;
  localparam logic [31:0] ESS_ONE         = 32'h0000_0001;

  typedef enum logic [1:0] {
    ESS_IDLE,
    ESS_EXPOSE,
    ESS_XFER,
    ESS_WAIT
  } ess_state_t;

endpackage

//--- hdl/ess_cycle_timer.sv
/*
  Down-counting cycle timer: a load pulse starts a count of load_val
  cycles (zero is taken as one) and done_ff stands high for one cycle,
  the last cycle of the count.
  Assumes a single clock sys_clk and an active-low asynchronous reset.
*/
module ess_cycle_timer (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        load,
  input  wire logic [31:0] load_val,
  output logic             done_ff
);

  // done is registered, so it is raised one count before the end
  localparam logic [31:0] NEXT_TO_LAST = ess_pkg::ESS_ONE
                                       + ess_pkg::ESS_ONE;

  logic [31:0] cnt_ff;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= '0;
    end else if (load) begin
      cnt_ff <= (load_val == '0) ? ess_pkg::ESS_ONE : load_val;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - ess_pkg::ESS_ONE;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      done_ff <= 1'b0;
    end else if (load) begin
      done_ff <= (load_val <= ess_pkg::ESS_ONE);
    end else begin
      done_ff <= (cnt_ff == NEXT_TO_LAST);
    end
  end

endmodule

//--- hdl/ess_exposure_sequencer.sv
/*
  Exposure start sequencer: starts exposures for single capture,
  free-run capture and software-triggered single capture, times the
  exposure from the shutter setting and paces free-run from the frame
  rate settings. Assumes downstream readout/transmit logic that takes
  readout_start_ff and pulses frame_sent when a frame has been sent,
  and a limit min_period (cycles) on the same clock.
*/
// How it works
// [R01] writing single capture 1 exposes and sends exactly one image
// [R02] single capture field clears itself once that image is sent
// [R03] host waits for the previous image before a new single capture
// [R04] writing free-run 1 starts exposure, later ones start on their own
// [R05] writing free-run 0 stops new exposures and transmission
// [R06] formats 0 to 2 pace free-run from the rate index field
// [R07] format 7 with manual rate off runs at the fastest allowed rate
// [R08] format 7 manual rate slower than the limit uses programmed rate
// [R09] format 7 manual rate faster than the limit is clamped to it
// [R10] software trigger starts programmable exposure of shutter length
// [R11] software trigger field clears only when a new exposure is safe
// [R12] host enables triggering by writing 1 to the trigger enable bit
// [R13] trigger source 7 selects the software trigger
// [R14] trigger mode 0 selects programmable exposure
// [R15] host arms with single capture first, then sets software trigger
// [R16] after the exposure time the image is read out and sent
// [R17] in triggered single capture the trigger clears after sending
// [R18] host waits for the image before arming the next trigger capture
// [R19] shot commands take exposure length from the shutter setting
// [R20] a software trigger without enable, source or arming is ignored
module ess_exposure_sequencer #(
  parameter logic [31:0] RATE_PERIOD [8] = '{
    32'd106666667, 32'd53333333, 32'd26666667, 32'd13333333,
    32'd6666667,   32'd3333333,  32'd1666667,  32'd833333
  }
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata_ff,
  input  wire logic        frame_sent,
  input  wire logic [31:0] min_period,
  output logic             expose_ff,
  output logic             readout_start_ff,
  output logic             xfer_stop_ff,
  output logic             capture_busy_ff
);

  ess_pkg::ess_state_t state_ff;
  ess_pkg::ess_state_t nxt_state;

  logic        single_ff;
  logic        free_ff;
  logic        trig_en_ff;
  logic [2:0]  trig_src_ff;
  logic [3:0]  trig_mode_ff;
  logic        sw_trig_ff;
  logic [31:0] shutter_ff;
  logic [2:0]  format_ff;
  logic [2:0]  rate_idx_ff;
  logic        man_rate_ff;
  logic [31:0] man_period_ff;
  logic        period_done_ff;
  logic [31:0] eff_period;
  logic        exp_done;
  logic        per_done;

  logic wr_ctrl;
  logic wr_sw;
  logic trig_sel;
  logic sw_go;
  logic one_go;
  logic fr_go;
  logic fr_stop;
  logic exp_load;
  logic xfer_done;

  assign wr_ctrl = reg_wr && (reg_addr == ess_pkg::ESS_REG_CTRL);
  assign wr_sw   = reg_wr && (reg_addr == ess_pkg::ESS_REG_SWTRIG);

  // software source and programmable mode chosen and triggering on
  assign trig_sel = trig_en_ff                                // see [R12]
                 && (trig_src_ff == ess_pkg::ESS_SRC_SOFT)    // see [R13]
                 && (trig_mode_ff == ess_pkg::ESS_MODE_PROG); // see [R14]

  // trigger taken only when armed by single capture and idle
  assign sw_go = wr_sw && reg_wdata[ess_pkg::ESS_SWTRIG_BIT]
              && trig_sel && single_ff && !sw_trig_ff
              && (state_ff == ess_pkg::ESS_IDLE);         // see [R20]
  assign one_go = wr_ctrl && reg_wdata[ess_pkg::ESS_CTRL_SINGLE]
               && !single_ff && !trig_sel
               && (state_ff == ess_pkg::ESS_IDLE);        // see [R01]
  assign fr_go = wr_ctrl && reg_wdata[ess_pkg::ESS_CTRL_FREE]
              && !free_ff && !trig_sel && !single_ff
              && (state_ff == ess_pkg::ESS_IDLE);         // see [R04]
  assign fr_stop = wr_ctrl && !reg_wdata[ess_pkg::ESS_CTRL_FREE]
                && free_ff && !single_ff
                && (state_ff != ess_pkg::ESS_IDLE);       // see [R05]
  assign xfer_done = (state_ff == ess_pkg::ESS_XFER) && frame_sent;

  // effective free-run frame period in cycles
  always_comb begin
    if (format_ff <= ess_pkg::ESS_FMT_MAX_FIXED) begin
      eff_period = RATE_PERIOD[rate_idx_ff];                // see [R06]
    end else if ((format_ff == ess_pkg::ESS_FMT_SCALABLE) && man_rate_ff
                 && (man_period_ff > min_period)) begin
      eff_period = man_period_ff;                           // see [R08]
    end else begin
      eff_period = min_period;                      // see [R07] see [R09]
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ess_pkg::ESS_IDLE: begin
        if (sw_go || one_go || fr_go) begin
          nxt_state = ess_pkg::ESS_EXPOSE;               // see [R10]
        end
      end
      ess_pkg::ESS_EXPOSE: begin
        if (fr_stop) begin
          nxt_state = ess_pkg::ESS_IDLE;
        end else if (exp_done) begin
          nxt_state = ess_pkg::ESS_XFER;                 // see [R16]
        end
      end
      ess_pkg::ESS_XFER: begin
        if (fr_stop) begin
          nxt_state = ess_pkg::ESS_IDLE;
        end else if (frame_sent) begin
          nxt_state = single_ff ? ess_pkg::ESS_IDLE : ess_pkg::ESS_WAIT;
        end
      end
      ess_pkg::ESS_WAIT: begin
        if (fr_stop) begin
          nxt_state = ess_pkg::ESS_IDLE;
        end else if (period_done_ff) begin
          nxt_state = ess_pkg::ESS_EXPOSE;               // see [R04]
        end
      end
      default: begin
        nxt_state = ess_pkg::ESS_IDLE;
      end
    endcase
  end

  assign exp_load = (state_ff != ess_pkg::ESS_EXPOSE)
                 && (nxt_state == ess_pkg::ESS_EXPOSE);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ess_pkg::ESS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // exposure length from the shutter setting
  ess_cycle_timer u_exp_timer (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .load     (exp_load),
    .load_val (shutter_ff),                              // see [R19]
    .done_ff  (exp_done)
  );

  // frame period counted from each exposure start
  ess_cycle_timer u_per_timer (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .load     (exp_load),
    .load_val (eff_period),
    .done_ff  (per_done)
  );

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      period_done_ff <= 1'b0;
    end else if (per_done) begin
      period_done_ff <= 1'b1;
    end else if (exp_load) begin
      period_done_ff <= 1'b0;
    end
  end

  // single capture request: a new write of 1 is taken only when idle, so the self-clear wins
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      single_ff <= 1'b0;
    end else if (wr_ctrl && reg_wdata[ess_pkg::ESS_CTRL_SINGLE]
                 && (state_ff == ess_pkg::ESS_IDLE)) begin
      single_ff <= 1'b1;
    end else if (xfer_done && single_ff) begin
      single_ff <= 1'b0;                                  // see [R02]
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      free_ff <= 1'b0;
    end else if (wr_ctrl) begin
      free_ff <= reg_wdata[ess_pkg::ESS_CTRL_FREE];
    end
  end

  // software trigger field holds until the image is sent
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sw_trig_ff <= 1'b0;
    end else if (sw_go) begin
      sw_trig_ff <= 1'b1;
    end else if (xfer_done) begin
      sw_trig_ff <= 1'b0;                         // see [R11] see [R17]
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      trig_en_ff   <= 1'b0;
      trig_src_ff  <= '0;
      trig_mode_ff <= '0;
    end else if (reg_wr && (reg_addr == ess_pkg::ESS_REG_TRIG)) begin
      trig_en_ff   <= reg_wdata[ess_pkg::ESS_TRIG_EN];
      trig_src_ff  <= reg_wdata[ess_pkg::ESS_TRIG_SRC_H:
                                ess_pkg::ESS_TRIG_SRC_L];
      trig_mode_ff <= reg_wdata[ess_pkg::ESS_TRIG_MOD_H:
                                ess_pkg::ESS_TRIG_MOD_L];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      shutter_ff <= ess_pkg::ESS_SHUTTER_RST;
    end else if (reg_wr && (reg_addr == ess_pkg::ESS_REG_SHUTTER)) begin
      shutter_ff <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      format_ff   <= '0;
      rate_idx_ff <= '0;
    end else if (reg_wr && (reg_addr == ess_pkg::ESS_REG_FORMAT)) begin
      format_ff   <= reg_wdata[ess_pkg::ESS_FMT_H:ess_pkg::ESS_FMT_L];
      rate_idx_ff <= reg_wdata[ess_pkg::ESS_RATE_H:ess_pkg::ESS_RATE_L];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      man_rate_ff   <= 1'b0;
      man_period_ff <= ess_pkg::ESS_FRPER_RST;
    end else if (reg_wr && (reg_addr == ess_pkg::ESS_REG_FRCTRL)) begin
      man_rate_ff <= reg_wdata[ess_pkg::ESS_FRCTRL_ON];
    end else if (reg_wr && (reg_addr == ess_pkg::ESS_REG_FRPER)) begin
      man_period_ff <= reg_wdata;
    end
  end

  // outputs toward the sensor and the readout path
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      expose_ff        <= 1'b0;
      readout_start_ff <= 1'b0;
      xfer_stop_ff     <= 1'b0;
      capture_busy_ff  <= 1'b0;
    end else begin
      expose_ff        <= (nxt_state == ess_pkg::ESS_EXPOSE);
      readout_start_ff <= (state_ff == ess_pkg::ESS_EXPOSE)
                       && (nxt_state == ess_pkg::ESS_XFER); // see [R16]
      xfer_stop_ff     <= fr_stop;                          // see [R05]
      capture_busy_ff  <= (nxt_state != ess_pkg::ESS_IDLE);
    end
  end

  // read data stand only in the cycle after the read strobe
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_ff <= '0;
    end else begin
      reg_rdata_ff <= '0;
      if (reg_rd) begin
        case (reg_addr)
          ess_pkg::ESS_REG_CTRL: begin
            reg_rdata_ff[ess_pkg::ESS_CTRL_SINGLE] <= single_ff;
            reg_rdata_ff[ess_pkg::ESS_CTRL_FREE]   <= free_ff;
          end
          ess_pkg::ESS_REG_TRIG: begin
            reg_rdata_ff[ess_pkg::ESS_TRIG_EN] <= trig_en_ff;
            reg_rdata_ff[ess_pkg::ESS_TRIG_SRC_H:ess_pkg::ESS_TRIG_SRC_L]
              <= trig_src_ff;
            reg_rdata_ff[ess_pkg::ESS_TRIG_MOD_H:ess_pkg::ESS_TRIG_MOD_L]
              <= trig_mode_ff;
          end
          ess_pkg::ESS_REG_SWTRIG: begin
            reg_rdata_ff[ess_pkg::ESS_SWTRIG_BIT] <= sw_trig_ff;
          end
          ess_pkg::ESS_REG_SHUTTER: begin
            reg_rdata_ff <= shutter_ff;
          end
          ess_pkg::ESS_REG_FORMAT: begin
            reg_rdata_ff[ess_pkg::ESS_FMT_H:ess_pkg::ESS_FMT_L] <= format_ff;
            reg_rdata_ff[ess_pkg::ESS_RATE_H:ess_pkg::ESS_RATE_L]
              <= rate_idx_ff;
          end
          ess_pkg::ESS_REG_FRCTRL: begin
            reg_rdata_ff[ess_pkg::ESS_FRCTRL_ON] <= man_rate_ff;
          end
          ess_pkg::ESS_REG_FRPER: begin
            reg_rdata_ff <= man_period_ff;
          end
          ess_pkg::ESS_REG_STATUS: begin
            reg_rdata_ff[ess_pkg::ESS_ST_STATE_H:ess_pkg::ESS_ST_STATE_L]
              <= state_ff;
            reg_rdata_ff[ess_pkg::ESS_ST_EXPOSE]  <= expose_ff;
            reg_rdata_ff[ess_pkg::ESS_ST_PERDONE] <= period_done_ff;
            reg_rdata_ff[ess_pkg::ESS_ST_TRIGSEL] <= trig_sel;
          end
          ess_pkg::ESS_REG_EFFPER: begin
            reg_rdata_ff <= eff_period;
          end
          default: begin
            reg_rdata_ff <= '0;
          end
        endcase
      end
    end
  end

endmodule

//--- bench/ess_exposure_sequencer_properties.sv
/*
  Checker for the exposure start sequencer, watching only its ports.
  Assumes one clock sys_clk and active-low asynchronous reset nrst.
*/
module ess_seq_checker (
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata_ff,
  input wire logic        frame_sent,
  input wire logic [31:0] min_period,
  input wire logic        expose_ff,
  input wire logic        readout_start_ff,
  input wire logic        xfer_stop_ff,
  input wire logic        capture_busy_ff
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  chk_readout_end: assert property (
    readout_start_ff |-> !expose_ff && $past(expose_ff))
    else $error("readout pulse without a finished exposure");
  chk_readout_pulse: assert property (
    readout_start_ff |=> !readout_start_ff [*2])
    else $error("readout pulse longer than one cycle");
  chk_fall_readout: assert property (
    $fell(expose_ff) |-> readout_start_ff || xfer_stop_ff)
    else $error("exposure ended without readout or stop");
  chk_read_idle: assert property (
    !$past(reg_rd) |-> reg_rdata_ff == 32'h0000_0000)
    else $error("read data outside the answer cycle");
  chk_start_cause: assert property (
    (!capture_busy_ff && !reg_wr) |=> !expose_ff)
    else $error("exposure started from idle without a write");
  chk_expose_busy: assert property (
    expose_ff |-> capture_busy_ff)
    else $error("exposing while not busy");
  chk_stop_quiet: assert property (
    xfer_stop_ff |-> !capture_busy_ff && !expose_ff)
    else $error("still active after free-run stop");
  chk_stop_cause: assert property (
    xfer_stop_ff |-> $past(reg_wr) &&
      $past(reg_addr) == ess_pkg::ESS_REG_CTRL)
    else $error("stop pulse without a control write");

  cover property ($rose(expose_ff));
  cover property (readout_start_ff);
  cover property (xfer_stop_ff);
endmodule

//--- bench/ess_xfer_model.sv
/*
  Model of the readout and transmit logic: after each readout start it
  pulses sent_ff once, delay + 1 cycles after it samples start.
  Assumes the sequencer clock and reset.
*/
module ess_xfer_model (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       start,
  input  wire logic [7:0] delay,
  output logic            sent_ff
);
  logic [7:0] cnt_ff;
  logic       busy_ff;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      busy_ff <= 1'b0;
      cnt_ff  <= 8'h00;
      sent_ff <= 1'b0;
    end else begin
      sent_ff <= 1'b0;
      if (start) begin
        busy_ff <= 1'b1;
        cnt_ff  <= delay;
      end else if (busy_ff) begin
        if (cnt_ff == 8'h00) begin
          sent_ff <= 1'b1;
          busy_ff <= 1'b0;
        end else begin
          cnt_ff <= cnt_ff - 8'h01;
        end
      end
    end
  end
endmodule

//--- bench/ess_exposure_sequencer_tb.sv
/*
  Testbench for the exposure start sequencer: register tasks, single,
  triggered and free-run captures against expected values.
  Assumes the transmit model and the checker bound below.
*/
module ess_exposure_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] min_period = 32'd50;
  logic [31:0] reg_rdata_ff;
  logic        frame_sent;
  logic        expose_ff;
  logic        readout_start_ff;
  logic        xfer_stop_ff;
  logic        capture_busy_ff;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          n;
  int          g;
  logic [31:0] fmt_v [5] = '{32'h10, 32'h22, 32'h7, 32'h7, 32'h7};
  logic [31:0] man_v [5] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h1};
  logic [31:0] per_v [5] = '{32'd0, 32'd0, 32'd0, 32'd100, 32'd30};
  logic [31:0] eff_v [5] = '{32'd80, 32'd90, 32'd50, 32'd100, 32'd50};

  always #2.5 sys_clk = ~sys_clk;

  ess_exposure_sequencer #(
    .RATE_PERIOD('{32'd60, 32'd80, 32'd90, 32'd100,
                   32'd110, 32'd120, 32'd130, 32'd140})
  ) ess_exposure_sequencer_inst (
    .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_ff(reg_rdata_ff), .frame_sent(frame_sent),
    .min_period(min_period), .expose_ff(expose_ff),
    .readout_start_ff(readout_start_ff), .xfer_stop_ff(xfer_stop_ff),
    .capture_busy_ff(capture_busy_ff)
  );

  ess_xfer_model ess_xfer_model_inst (
    .sys_clk(sys_clk), .nrst(nrst), .start(readout_start_ff),
    .delay(8'h05), .sent_ff(frame_sent)
  );

  task automatic final_report;
    $display("mismatches %0d, checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata_ff, exp);
  endtask

  // counts exposing cycles, or non-exposing cycles up to the next exposure
  task automatic count_lvl(input logic lvl, output int c);
    c = 0;
    while (expose_ff === lvl && c < 1000) begin
      c++;
      @(posedge sys_clk);
      #1;
    end
    if (c >= 1000) begin
      num_errors++;
      final_report();
    end
  endtask

  task automatic wait_idle;
    for (int i = 0; i < 500 && capture_busy_ff !== 1'b0; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk({31'h0, capture_busy_ff}, 32'h0);
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk);
    num_errors++;
    final_report();
  end

  initial begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    chk_rd(ess_pkg::ESS_REG_SHUTTER, ess_pkg::ESS_SHUTTER_RST);
    chk_rd(ess_pkg::ESS_REG_CTRL, 32'h0);
    wr(8'h24, 32'hffff_ffff);
    chk_rd(8'h24, 32'h0);
    wr(ess_pkg::ESS_REG_SHUTTER, 32'h3);
    wr(ess_pkg::ESS_REG_CTRL, 32'h1);
    count_lvl(1'b1, n);
    chk(n, 32'd3);
    chk({31'h0, readout_start_ff}, 32'h1);
    chk_rd(ess_pkg::ESS_REG_CTRL, 32'h1);
    wait_idle();
    chk_rd(ess_pkg::ESS_REG_CTRL, 32'h0);
    wr(ess_pkg::ESS_REG_SWTRIG, 32'h1);
    chk({31'h0, expose_ff}, 32'h0);
    chk_rd(ess_pkg::ESS_REG_SWTRIG, 32'h0);
    wr(ess_pkg::ESS_REG_TRIG, 32'hf);
    wr(ess_pkg::ESS_REG_SWTRIG, 32'h1);
    chk({31'h0, expose_ff}, 32'h0);
    wr(ess_pkg::ESS_REG_CTRL, 32'h1);
    chk({31'h0, expose_ff}, 32'h0);
    wr(ess_pkg::ESS_REG_SWTRIG, 32'h1);
    count_lvl(1'b1, n);
    chk(n, 32'd3);
    chk_rd(ess_pkg::ESS_REG_SWTRIG, 32'h1);
    wait_idle();
    chk_rd(ess_pkg::ESS_REG_SWTRIG, 32'h0);
    chk_rd(ess_pkg::ESS_REG_CTRL, 32'h0);
    wr(ess_pkg::ESS_REG_TRIG, 32'h0);
    for (int k = 0; k < 5; k++) begin
      wr(ess_pkg::ESS_REG_FORMAT, fmt_v[k]);
      wr(ess_pkg::ESS_REG_FRCTRL, man_v[k]);
      wr(ess_pkg::ESS_REG_FRPER, per_v[k]);
      chk_rd(ess_pkg::ESS_REG_EFFPER, eff_v[k]);
      wr(ess_pkg::ESS_REG_CTRL, 32'h2);
      count_lvl(1'b1, n);
      count_lvl(1'b0, g);
      g = g + n;
      // next start comes one cycle after the period is counted out
      chk(g, eff_v[k] + 32'd1);
      wr(ess_pkg::ESS_REG_CTRL, 32'h0);
      chk({31'h0, xfer_stop_ff}, 32'h1);
      n = 0;
      repeat (150) begin
        @(posedge sys_clk);
        #1;
        n += (expose_ff !== 1'b0);
      end
      chk(n, 32'd0);
    end
    final_report();
  end
endmodule

bind ess_exposure_sequencer ess_seq_checker ess_seq_checker_inst (
  .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_ff(reg_rdata_ff), .frame_sent(frame_sent),
  .min_period(min_period), .expose_ff(expose_ff),
  .readout_start_ff(readout_start_ff), .xfer_stop_ff(xfer_stop_ff),
  .capture_busy_ff(capture_busy_ff)
);
